// ===== spc_pkg.sv
// package: register map, field layout and mode encodings for the serial setup block
package spc_pkg;
    localparam int SPC_AW = 13;
    localparam logic [12:0] SPC_SETUP0_OFS = 13'h1F83;
    localparam logic [12:0] SPC_SETUP1_OFS = 13'h1F8B;
    localparam logic [12:0] SPC_STATE0_OFS = 13'h1F90;
    localparam logic [12:0] SPC_STATE1_OFS = 13'h1F91;
    localparam logic [12:0] SPC_IRQ_ST_OFS = 13'h1F92;
    localparam logic [12:0] SPC_IRQ_MASK_OFS = 13'h1F93;
    localparam logic [7:0] SPC_SETUP_RST = 8'h00;
    localparam logic [7:0] SPC_IRQ_RST = 8'h00;
    // setup field positions
    localparam int SPC_B_MODE_LO = 0;
    localparam int SPC_B_PARITY_ON = 2;
    localparam int SPC_B_RX_EN = 3;
    localparam int SPC_B_NINTH = 4;
    localparam int SPC_B_ODD = 5;
    localparam int SPC_B_CLK_IN = 6;
    localparam int SPC_B_MODE_HI = 7;
    // state register fields
    localparam int SPC_B_PERR = 7;
    localparam int SPC_B_NINTH_RX = 7;
    localparam int SPC_B_RX_DONE = 6;
    localparam int SPC_B_TX_DONE = 5;
    localparam int SPC_NCH = 2;

    typedef enum logic [2:0] {
        SPC_MODE0, SPC_MODE1, SPC_MODE2, SPC_MODE3, SPC_MODE4
    } spc_mode_t;

    typedef struct packed {
        logic [12:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } spc_bus_t;

    typedef struct packed {
        logic rx_done;   // frame received, one-cycle pulse
        logic rx_ninth;  // received ninth bit
        logic tx_done;   // frame sent, one-cycle pulse
    } spc_ev_t;

    typedef struct packed {
        spc_mode_t mode;
        logic rx_en;
        logic parity_on;
        logic odd;
        logic clk_in;
        logic tx_ninth;
    } spc_cfg_t;
endpackage

// ===== spc_setup.sv
// serial setup registers, mode decode, parity path and receive status per channel
// Operation
// - one 8-bit setup register per channel
// - clearing receive enable aborts, blocks receptions
// - parity generate and check in modes 1,3
// - parity replaces written ninth transmit bit
// - state bit 7 becomes parity error flag
// - mode from bit 7 and bits 1:0
// - setup registers reset to zero, separate addresses
// - bit 6 selects shift clock direction
// - bit 5 selects even or odd parity
// - ninth bit cleared after each transmission unless a setup write lands in the same cycle
module spc_setup (
    input wire logic core_clk, // core clock
    input wire logic sys_rst, // synchronous reset, active high
    input wire spc_pkg::spc_bus_t bus, // register bus request
    output logic [7:0] rdata, // read data, cycle after read strobe
    input wire spc_pkg::spc_ev_t [1:0] ev, // per-channel frame events
    input wire logic [1:0][7:0] rx_data, // received data per channel
    output spc_pkg::spc_cfg_t [1:0] cfg, // per-channel decoded setup
    output logic [1:0] tx_bit8, // ninth bit to send
    output logic [1:0] rx_abort, // abort reception in progress
    output logic irq // interrupt, high while unmasked status set
);
    import spc_pkg::*;

    logic [1:0][7:0] setup_q;
    logic [1:0] perr_q;
    logic [1:0] ninth_rx_q;
    logic [1:0] rx_done_q;
    logic [1:0] tx_done_q;
    logic [7:0] irq_st_q;
    logic [7:0] irq_mask_q;
    logic [7:0] rdata_q;
    logic [1:0] abort_q;
    logic irq_q;
    spc_cfg_t [1:0] cfg_q;
    logic [1:0] bit8_q;
    logic [1:0] rx_ok;
    logic [1:0] par_rx;
    logic [1:0] par_chk;
    logic [7:0] irq_set;
    logic [7:0] rdata_d;
    logic sel_setup0;
    logic sel_setup1;
    logic sel_state0;
    logic sel_state1;
    logic sel_irq_st;
    logic sel_irq_mask;
    logic irq_st_wr;
    logic irq_mask_wr;
    logic irq_any;

    // -----------------------------------------------------------------
    // address decode
    // -----------------------------------------------------------------
    // one compare per register feeds the read mux and interrupt writes; setup writes and state reads compare again per channel
    assign sel_setup0 = (bus.addr == SPC_SETUP0_OFS);
    assign sel_setup1 = (bus.addr == SPC_SETUP1_OFS);
    assign sel_state0 = (bus.addr == SPC_STATE0_OFS);
    assign sel_state1 = (bus.addr == SPC_STATE1_OFS);
    assign sel_irq_st = (bus.addr == SPC_IRQ_ST_OFS);
    assign sel_irq_mask = (bus.addr == SPC_IRQ_MASK_OFS);
    assign irq_st_wr = bus.wr && sel_irq_st;
    assign irq_mask_wr = bus.wr && sel_irq_mask;

    // -----------------------------------------------------------------
    // per-channel setup register and status
    // -----------------------------------------------------------------
    genvar c;
    generate
        for (c = 0; c < SPC_NCH; c++) begin : g_ch
            logic wr_setup;
            logic rd_state;
            logic [2:0] mode_field;
            spc_mode_t mode;
            logic par_active;
            logic tx_par;
            logic clr_rx_en;
            logic rx_take;
            logic tx_end;

            assign wr_setup = bus.wr && (bus.addr == (c == 0 ? SPC_SETUP0_OFS : SPC_SETUP1_OFS));
            assign rd_state = bus.rd && (bus.addr == (c == 0 ? SPC_STATE0_OFS : SPC_STATE1_OFS));
            // -----------------------------------------------------------------
            // mode decode
            // -----------------------------------------------------------------
            // high bit plus the two low bits form the mode field
            assign mode_field = {setup_q[c][SPC_B_MODE_HI], setup_q[c][1:0]};

            always_comb begin
                unique case (mode_field)
                    3'h0: mode = SPC_MODE0;
                    3'h1: mode = SPC_MODE1;
                    3'h2: mode = SPC_MODE2;
                    3'h3: mode = SPC_MODE3;
                    3'h4: mode = SPC_MODE4;
                    3'h5: mode = SPC_MODE1;
                    3'h6: mode = SPC_MODE2;
                    3'h7: mode = SPC_MODE3;
                endcase
            end

            // -----------------------------------------------------------------
            // parity path
            // -----------------------------------------------------------------
            // mode 2 with parity on is left to software to avoid
            assign par_active = setup_q[c][SPC_B_PARITY_ON]
                && (mode == SPC_MODE1 || mode == SPC_MODE3);
            // even parity makes total ones even; odd flips it
            assign tx_par = setup_q[c][SPC_B_ODD];
            // folds to one when the count of ones breaks the chosen sense
            assign par_rx[c] = ^rx_data[c] ^ ev[c].rx_ninth ^ setup_q[c][SPC_B_ODD];
            assign par_chk[c] = par_active;

            // -----------------------------------------------------------------
            // receive enable and frame acceptance
            // -----------------------------------------------------------------
            // with the enable off a finished frame is dropped whole, never half taken
            assign rx_ok[c] = setup_q[c][SPC_B_RX_EN];
            assign rx_take = ev[c].rx_done && rx_ok[c];
            assign tx_end = ev[c].tx_done;

            // -----------------------------------------------------------------
            // setup register
            // -----------------------------------------------------------------
            // a write wins over the ninth-bit clear of a frame end
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    setup_q[c] <= SPC_SETUP_RST;
                end else if (wr_setup) begin
                    setup_q[c] <= bus.wdata;
                end else if (ev[c].tx_done) begin
                    setup_q[c][SPC_B_NINTH] <= 1'b0;
                end
            end

            // a write that drops receive enable while it is still on
            assign clr_rx_en = wr_setup && setup_q[c][SPC_B_RX_EN]
                && !bus.wdata[SPC_B_RX_EN];

            // one-cycle abort pulse toward the receive shifter
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    abort_q[c] <= 1'b0;
                end else begin
                    abort_q[c] <= clr_rx_en;
                end
            end

            // -----------------------------------------------------------------
            // receive and transmit status
            // -----------------------------------------------------------------
            // a new frame wins over a clearing read in the same cycle
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    rx_done_q[c] <= 1'b0;
                end else if (rx_take) begin
                    rx_done_q[c] <= 1'b1;
                end else if (rd_state) begin
                    rx_done_q[c] <= 1'b0;
                end
            end

            // parity error follows the same set-wins policy
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    perr_q[c] <= 1'b0;
                end else if (rx_take) begin
                    perr_q[c] <= par_chk[c] && par_rx[c];
                end else if (rd_state) begin
                    perr_q[c] <= 1'b0;
                end
            end

            // ninth bit kept until the next frame, a read leaves it alone
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    ninth_rx_q[c] <= 1'b0;
                end else if (rx_take) begin
                    ninth_rx_q[c] <= ev[c].rx_ninth;
                end
            end

            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    tx_done_q[c] <= 1'b0;
                end else if (tx_end) begin
                    tx_done_q[c] <= 1'b1;
                end else if (rd_state) begin
                    tx_done_q[c] <= 1'b0;
                end
            end

            // -----------------------------------------------------------------
            // decoded setup toward the shifters
            // -----------------------------------------------------------------
            // registered so the shifters see a whole write at once
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    cfg_q[c] <= '0;
                end else begin
                    cfg_q[c].mode <= mode;
                    cfg_q[c].rx_en <= setup_q[c][SPC_B_RX_EN];
                    cfg_q[c].parity_on <= par_active;
                    cfg_q[c].odd <= setup_q[c][SPC_B_ODD];
                    cfg_q[c].clk_in <= setup_q[c][SPC_B_CLK_IN];
                    cfg_q[c].tx_ninth <= setup_q[c][SPC_B_NINTH];
                end
            end

            // parity bit is finished by the shifter over the data byte
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    bit8_q[c] <= 1'b0;
                end else if (par_active) begin
                    bit8_q[c] <= tx_par;
                end else begin
                    bit8_q[c] <= setup_q[c][SPC_B_NINTH];
                end
            end

            // -----------------------------------------------------------------
            // interrupt sources
            // -----------------------------------------------------------------
            // a refused frame raises no interrupt either
            assign irq_set[2*c] = rx_take;
            assign irq_set[2*c+1] = tx_end;
        end
    endgenerate
    assign irq_set[7:4] = 4'h0;

    // -----------------------------------------------------------------
    // interrupt status and mask
    // -----------------------------------------------------------------
    // bit 0 rx ch0, bit 1 tx ch0, bit 2 rx ch1, bit 3 tx ch1, upper bits spare
    // a set in the same cycle as a clearing write wins, so no event is lost
    genvar b;
    generate
        for (b = 0; b < 8; b++) begin : g_irq
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    irq_st_q[b] <= SPC_IRQ_RST[b];
                end else if (irq_set[b]) begin
                    irq_st_q[b] <= 1'b1;
                end else if (irq_st_wr && bus.wdata[b]) begin
                    irq_st_q[b] <= 1'b0;
                end
            end

            // the mask only gates the output, status keeps collecting
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    irq_mask_q[b] <= SPC_IRQ_RST[b];
                end else if (irq_mask_wr) begin
                    irq_mask_q[b] <= bus.wdata[b];
                end
            end
        end
    endgenerate

    assign irq_any = |(irq_st_q & irq_mask_q);

    // level output, one cycle behind the status and mask it reflects
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_any;
        end
    end

    // -----------------------------------------------------------------
    // read mux
    // -----------------------------------------------------------------
    function automatic logic [7:0] state_word(input logic po, input logic pe,
                                              input logic n9, input logic rd,
                                              input logic td);
        logic [7:0] w;
        w = 8'h00;
        w[SPC_B_PERR] = pe ? po : n9;
        w[SPC_B_RX_DONE] = rd;
        w[SPC_B_TX_DONE] = td;
        return w;
    endfunction

    // unmapped addresses read as zero
    always_comb begin
        rdata_d = 8'h00;
        if (bus.rd && sel_setup0) begin
            rdata_d = setup_q[0];
        end else if (bus.rd && sel_setup1) begin
            rdata_d = setup_q[1];
        end else if (bus.rd && sel_state0) begin
            rdata_d = state_word(perr_q[0], par_chk[0], ninth_rx_q[0], rx_done_q[0],
                                 tx_done_q[0]);
        end else if (bus.rd && sel_state1) begin
            rdata_d = state_word(perr_q[1], par_chk[1], ninth_rx_q[1], rx_done_q[1],
                                 tx_done_q[1]);
        end else if (bus.rd && sel_irq_st) begin
            rdata_d = irq_st_q;
        end else if (bus.rd && sel_irq_mask) begin
            rdata_d = irq_mask_q;
        end
    end

    // read data stand for one cycle only, zero between reads
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // -----------------------------------------------------------------
    // outputs, each straight from a flip-flop
    // -----------------------------------------------------------------
    assign rdata = rdata_q;
    assign cfg = cfg_q;
    assign tx_bit8 = bit8_q;
    assign rx_abort = abort_q;
    assign irq = irq_q;
endmodule

// ===== spc_setup_assertions.sv
// port checker of the serial setup block
module spc_chk (
    input wire logic core_clk, // clock
    input wire logic sys_rst, // reset
    input wire spc_pkg::spc_bus_t bus, // bus
    input wire logic [7:0] rdata, // read data
    input wire spc_pkg::spc_ev_t [1:0] ev, // events
    input wire spc_pkg::spc_cfg_t [1:0] cfg, // setup
    input wire logic [1:0] tx_bit8, // ninth bit
    input wire logic [1:0] rx_abort, // abort
    input wire logic irq // interrupt
);
    import spc_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic hit;
    logic cause;
    logic clr_q;
    logic [1:0] hit_q;
    logic [1:0][7:0] wd_q;
    assign hit = bus.wr && bus.addr == SPC_SETUP0_OFS;
    assign cause = bus.wr || ev[0].rx_done || ev[1].rx_done || ev[0].tx_done || ev[1].tx_done;
    // cfg trails a write by two edges, so the write is piped alongside
    always_ff @(posedge core_clk) begin
        hit_q <= {hit_q[0], hit};
        wd_q <= {wd_q[0], bus.wdata};
        clr_q <= hit && !bus.wdata[SPC_B_RX_EN];
    end
    a_reset_clear: assert property ($past(sys_rst) |->
        !irq && rdata == 8'h00 && cfg == '0) else $error("outputs not clear after reset");
    a_mode_decode: assert property (hit_q[1] |-> cfg[0].mode ==
        (wd_q[1][1:0] != 2'h0 ? spc_mode_t'({1'b0, wd_q[1][1:0]}) :
        wd_q[1][7] ? SPC_MODE4 : SPC_MODE0)) else $error("mode decode wrong");
    a_setup_fields: assert property (hit_q[1] |->
        cfg[0].parity_on == (wd_q[1][2] & wd_q[1][0]) && cfg[0].odd == wd_q[1][5]
        && cfg[0].clk_in == wd_q[1][6]) else $error("setup fields wrong");
    a_ninth_parity: assert property (cfg[0].parity_on |-> tx_bit8[0] == cfg[0].odd)
        else $error("ninth bit not parity");
    a_abort_cause: assert property (rx_abort[0] |-> clr_q)
        else $error("abort without clearing write");
    a_abort_pulse: assert property (rx_abort[1] |=> !rx_abort[1])
        else $error("abort longer than one cycle");
    a_read_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
        else $error("read data outside read slot");
    a_irq_cause: assert property ($rose(irq) |-> $past(cause, 2))
        else $error("interrupt without cause");
endmodule
bind spc_setup spc_chk u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
    .ev(ev), .cfg(cfg), .tx_bit8(tx_bit8), .rx_abort(rx_abort), .irq(irq));

// ===== spc_far.sv
// line partner model: turns bench commands into frame events
module spc_far (
    input wire logic core_clk, // clock
    input wire logic [1:0] rx_go, // frame in
    input wire logic [1:0] tx_go, // frame out
    input wire logic [8:0] frame, // ninth bit, byte
    output spc_pkg::spc_ev_t [1:0] ev, // events
    output logic [1:0][7:0] rx_data // bytes
);
    import spc_pkg::*;
    // stale byte lines toggle so unqualified data never looks valid
    always_ff @(posedge core_clk) begin
        for (int c = 0; c < SPC_NCH; c++) begin
            ev[c] <= '{rx_go[c], rx_go[c] ? frame[8] : !ev[c].rx_ninth, tx_go[c]};
            rx_data[c] <= rx_go[c] ? frame[7:0] : ~rx_data[c];
        end
    end
endmodule

// ===== tb.sv
// bench for the serial setup block
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import spc_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    spc_bus_t bus = '0;
    logic [1:0] rx_go = 2'h0, tx_go = 2'h0, tx_bit8, rx_abort;
    logic [8:0] frame = 9'h000;
    logic [7:0] rdata;
    logic irq;
    spc_ev_t [1:0] ev;
    logic [1:0][7:0] rx_data;
    spc_cfg_t [1:0] cfg;
    int err_total = 0;
    int n_compared = 0;
    initial begin
        forever #20 core_clk = ~core_clk;
    end
    spc_setup dut (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata), .ev(ev),
        .rx_data(rx_data), .cfg(cfg), .tx_bit8(tx_bit8), .rx_abort(rx_abort), .irq(irq));
    spc_far far (.core_clk(core_clk), .rx_go(rx_go), .tx_go(tx_go), .frame(frame), .ev(ev),
        .rx_data(rx_data));
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic w(input logic [12:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask
    task automatic r(input logic [12:0] a, input logic [7:0] e);
        @(posedge core_clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1 chk($sformatf("reg %h", a), e, rdata);
    endtask
    task automatic fr(input logic [1:0] rx, input logic [1:0] tx, input logic [8:0] f,
                      input logic e_irq);
        @(posedge core_clk);
        rx_go <= rx;
        tx_go <= tx;
        frame <= f;
        @(posedge core_clk);
        rx_go <= 2'h0;
        tx_go <= 2'h0;
        repeat (3) @(posedge core_clk);
        #1 chk("irq", {7'h00, e_irq}, {7'h00, irq});
    endtask
    task automatic s_abort();
        chk("cfg reset", 8'h00, cfg[0]);
        r(13'h1F84, 8'h00);
        w(SPC_SETUP0_OFS, 8'h09);
        w(SPC_SETUP0_OFS, 8'h01);
        #1 chk("abort", 8'h01, {6'h00, rx_abort});
        fr(2'h1, 2'h0, 9'h055, 1'b0);
        r(SPC_STATE0_OFS, 8'h00);
        r(SPC_IRQ_ST_OFS, 8'h00);
        w(SPC_SETUP1_OFS, 8'h08);
        w(SPC_SETUP1_OFS, 8'h13);
        #1 chk("abort ch1", 8'h02, {6'h00, rx_abort});
        fr(2'h0, 2'h2, 9'h000, 1'b0);
        r(SPC_SETUP1_OFS, 8'h03);
        r(SPC_STATE1_OFS, 8'h20);
    endtask
    task automatic s_modes();
        logic [7:0] d;
        logic p;
        for (int c = 0; c < 2; c++) begin
            for (int i = 0; i < 8; i++) begin
                p = (i % 4 != 2);
                d = {i[2], i[0], i[1], 1'b1, 1'b0, p, i[1:0]};
                w(c ? SPC_SETUP1_OFS : SPC_SETUP0_OFS, d);
                @(posedge core_clk);
                #1 chk("mode", 8'(i % 4 != 0 ? i % 4 : i & 4), 8'(cfg[c].mode));
                chk("parity", {7'h00, p & i[0]}, {7'h00, cfg[c].parity_on});
                chk("ninth", {7'h00, (p & i[0]) ? i[1] : 1'b1}, {7'h00, tx_bit8[c]});
                chk("clk dir", {7'h00, i[0]}, {7'h00, cfg[c].clk_in});
                chk("odd", {7'h00, i[1]}, {7'h00, cfg[c].odd});
                chk("ninth set", 8'h01, {7'h00, cfg[c].tx_ninth});
                chk("rx off", 8'h00, {7'h00, cfg[c].rx_en});
                r(c ? SPC_SETUP1_OFS : SPC_SETUP0_OFS, d);
            end
        end
        r(SPC_SETUP0_OFS, 8'hF7);
    endtask
    task automatic s_rx();
        w(SPC_IRQ_MASK_OFS, 8'h01);
        w(SPC_SETUP0_OFS, 8'h0D);
        fr(2'h1, 2'h0, 9'h001, 1'b1);
        chk("irq up", 8'h01, 8'(irq));
        r(SPC_STATE0_OFS, 8'hC0);
        fr(2'h1, 2'h0, 9'h003, 1'b1);
        r(SPC_STATE0_OFS, 8'h40);
        w(SPC_SETUP0_OFS, 8'h0B);
        fr(2'h1, 2'h0, 9'h100, 1'b1);
        r(SPC_STATE0_OFS, 8'hC0);
        r(SPC_IRQ_ST_OFS, 8'h09);
        w(SPC_IRQ_MASK_OFS, 8'h00);
        @(posedge core_clk);
        #1 chk("irq masked", 8'h00, 8'(irq));
        w(SPC_IRQ_ST_OFS, 8'h0F);
        w(SPC_IRQ_MASK_OFS, 8'h01);
        @(posedge core_clk);
        #1 chk("irq cleared", 8'h00, 8'(irq));
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        s_abort();
        s_modes();
        s_rx();
        complete_run();
    end
endmodule
